// ---- include/sbac_map.vh ----
`ifndef SBAC_MAP_VH
`define SBAC_MAP_VH

// ----------------------------------------------------------------
// Register indices (word addresses on the CSR port)
// ----------------------------------------------------------------
`define SBAC_IDX_CFG 16'h1c00
`define SBAC_IDX_DROP 16'h1c01
`define SBAC_IDX_PAUSE 16'h1c02
`define SBAC_IDX_RESUME 16'h1c03
`define SBAC_IDX_FLOOD 16'h1c04
`define SBAC_IDX_CNT0 16'h1c05

// ----------------------------------------------------------------
// Config field positions
// ----------------------------------------------------------------
`define SBAC_CFG_RED 0
`define SBAC_CFG_YEL 1
`define SBAC_CFG_EGR_LO 2
`define SBAC_CFG_EGR_HI 4
`define SBAC_CFG_FIXPRI 5
`define SBAC_CFG_CTEST 6
`define SBAC_CFG_W 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SBAC_CFG_RST 7'h00
`define SBAC_DROP_LO_RST 8'h49
`define SBAC_DROP_HI_RST 8'h64
`define SBAC_PAUSE_LO_RST 8'h21
`define SBAC_PAUSE_HI_RST 8'h3c
`define SBAC_RESUME_LO_RST 8'h03
`define SBAC_RESUME_HI_RST 8'h07
`define SBAC_FLOOD_RST 8'h31
`define SBAC_CNT_RST 32'h00000000

// ----------------------------------------------------------------
// Constants
// ----------------------------------------------------------------
`define SBAC_ACTIVE_LVL 8'h24
`define SBAC_CNT_MAX 32'hffffffff
`define SBAC_CNT_TEST 32'h7ffffffc
`define SBAC_BUF_BYTES 128
`define SBAC_LVL_W 8

`endif

// ---- src/sbac_drop_counter.v ----
`timescale 1ns/1ps
`include "sbac_map.vh"

module sbac_drop_counter (
  input wire clk_sys,
  input wire rst,
  input wire drop,
  input wire rd_clr,
  input wire test_mode,
  output reg [31:0] count_reg
);

  reg [31:0] count_next;

  // Read-clear wins only for the value already read; a drop in the
  // same cycle is counted on top so it is not lost.
  always @* begin
    count_next = count_reg;
    if (rd_clr) begin
      if (test_mode) begin
        count_next = `SBAC_CNT_TEST; // see (R01)
      end else begin
        count_next = `SBAC_CNT_RST; // see (R14)
      end
    end
    if (drop && count_next != `SBAC_CNT_MAX) begin
      count_next = count_next + 32'h00000001; // see (R13) (R15)
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= `SBAC_CNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// ---- src/sbac_top.v ----
// Behaviour
// (R01) Counter test bit set: a read loads 7FFF_FFFC instead of zero.
// (R02) Queue service bit one: fixed priority; zero: weighted round robin.
// (R03) Egress pacing enable field bits 4:2 map to ports 2,1,0.
// (R04) Yellow discard enable: yellow packets subject to random discard.
// (R05) Red discard enable: every red packet is discarded.
// (R06) A port is active when it holds at least 36 buffers.
// (R07) All levels and limits count 128-byte buffers.
// (R08) Two or three ports active: per-port cap is low drop limit.
// (R09) One port active: per-port cap is high drop limit.
// (R10) Pause when usage reaches pause threshold, low or high by activity.
// (R11) Resume pause frame when usage falls to resume threshold.
// (R12) Flood traffic total buffers capped at broadcast drop level.
// (R13) 32-bit counter counts port 0 buffer manager drops.
// (R14) Reading port 0 counter returns value, then clears it.
// (R15) Drop counter saturates at all ones.
// (R16) Packet exceeding its port drop limit is dropped and counted.
// (R17) Reserved bits read zero; writes to them ignored.
`timescale 1ns/1ps
`include "sbac_map.vh"

module sbac_top (
  input wire clk_sys,
  input wire rst,
  // CSR port, word-indexed
  input wire csr_wr,
  input wire csr_rd,
  input wire [15:0] csr_addr,
  input wire [31:0] csr_wdata,
  output reg [31:0] csr_rdata_reg,
  // Buffer usage per ingress port, flood total
  input wire [23:0] port_used,
  input wire [7:0] flood_used,
  // Admission request per port
  input wire [2:0] adm_req,
  input wire [2:0] adm_flood,
  input wire [2:0] adm_yellow,
  input wire [2:0] adm_red,
  input wire [2:0] adm_rand_hit,
  output reg [2:0] adm_drop_reg,
  output reg [2:0] adm_accept_reg,
  // Flow control
  output reg [2:0] fc_pause_reg,
  output reg [2:0] fc_resume_reg,
  output reg [2:0] fc_hold_reg,
  // Static controls, port 0 drop count
  output reg [2:0] egress_pace_en_reg,
  output reg fixed_prio_reg,
  output reg [31:0] drop_cnt0_reg
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  reg [`SBAC_CFG_W-1:0] cfg_reg;
  reg [7:0] drop_lo_reg;
  reg [7:0] drop_hi_reg;
  reg [7:0] pause_lo_reg;
  reg [7:0] pause_hi_reg;
  reg [7:0] resume_lo_reg;
  reg [7:0] resume_hi_reg;
  reg [7:0] flood_cap_reg;

  wire wr_cfg = csr_wr && (csr_addr == `SBAC_IDX_CFG);
  wire wr_drop = csr_wr && (csr_addr == `SBAC_IDX_DROP);
  wire wr_pause = csr_wr && (csr_addr == `SBAC_IDX_PAUSE);
  wire wr_resume = csr_wr && (csr_addr == `SBAC_IDX_RESUME);
  wire wr_flood = csr_wr && (csr_addr == `SBAC_IDX_FLOOD);
  wire rd_cnt0 = csr_rd && (csr_addr == `SBAC_IDX_CNT0);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_reg <= `SBAC_CFG_RST;
      drop_lo_reg <= `SBAC_DROP_LO_RST;
      drop_hi_reg <= `SBAC_DROP_HI_RST;
      pause_lo_reg <= `SBAC_PAUSE_LO_RST;
      pause_hi_reg <= `SBAC_PAUSE_HI_RST;
      resume_lo_reg <= `SBAC_RESUME_LO_RST;
      resume_hi_reg <= `SBAC_RESUME_HI_RST;
      flood_cap_reg <= `SBAC_FLOOD_RST;
    end else begin
      // Only implemented bits are stored
      if (wr_cfg) begin
        cfg_reg <= csr_wdata[`SBAC_CFG_W-1:0]; // see (R17)
      end
      if (wr_drop) begin
        drop_lo_reg <= csr_wdata[15:8];
        drop_hi_reg <= csr_wdata[7:0];
      end
      if (wr_pause) begin
        pause_lo_reg <= csr_wdata[15:8];
        pause_hi_reg <= csr_wdata[7:0];
      end
      if (wr_resume) begin
        resume_lo_reg <= csr_wdata[15:8];
        resume_hi_reg <= csr_wdata[7:0];
      end
      if (wr_flood) begin
        flood_cap_reg <= csr_wdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  reg [31:0] rdata_next;
  wire [31:0] cnt0;

  always @* begin
    rdata_next = 32'h00000000;
    case (csr_addr)
      `SBAC_IDX_CFG: rdata_next = {25'h0000000, cfg_reg}; // see (R17)
      `SBAC_IDX_DROP: rdata_next = {16'h0000, drop_lo_reg, drop_hi_reg};
      `SBAC_IDX_PAUSE: rdata_next = {16'h0000, pause_lo_reg, pause_hi_reg};
      `SBAC_IDX_RESUME:
        rdata_next = {16'h0000, resume_lo_reg, resume_hi_reg};
      `SBAC_IDX_FLOOD: rdata_next = {24'h000000, flood_cap_reg};
      `SBAC_IDX_CNT0: rdata_next = cnt0; // see (R14)
      default: rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      csr_rdata_reg <= 32'h00000000;
    end else if (csr_rd) begin
      csr_rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Port activity and threshold selection
  // ----------------------------------------------------------------
  // Levels are in 128-byte buffers throughout; no byte math here.
  wire [2:0] active; // see (R07)
  wire [1:0] n_active = {1'b0, active[0]} + {1'b0, active[1]} +
                        {1'b0, active[2]};
  wire multi = (n_active >= 2'd2);
  wire [7:0] drop_lim = multi ? drop_lo_reg : drop_hi_reg; // see (R08) (R09)
  wire [7:0] pause_lim = multi ? pause_lo_reg : pause_hi_reg; // see (R10)
  wire [7:0] resume_lim = multi ? resume_lo_reg : resume_hi_reg; // see (R11)

  wire red_en = cfg_reg[`SBAC_CFG_RED];
  wire yel_en = cfg_reg[`SBAC_CFG_YEL];
  wire flood_full = (flood_used >= flood_cap_reg);
  wire [2:0] drop_now;

  // ----------------------------------------------------------------
  // Per-port admission and flow control
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_port
      wire [7:0] used = port_used[gi*8 +: 8];
      assign active[gi] = (used >= `SBAC_ACTIVE_LVL); // see (R06)
      // Taking one more buffer must not pass the limit
      wire over = (used >= drop_lim); // see (R16)
      wire flood_over = adm_flood[gi] && flood_full; // see (R12)
      wire red_drop = red_en && adm_red[gi]; // see (R05)
      wire yel_drop = yel_en && adm_yellow[gi] &&
                      adm_rand_hit[gi]; // see (R04)
      assign drop_now[gi] = adm_req[gi] &&
                            (over || flood_over || red_drop || yel_drop);

      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          adm_drop_reg[gi] <= 1'b0;
          adm_accept_reg[gi] <= 1'b0;
          fc_pause_reg[gi] <= 1'b0;
          fc_resume_reg[gi] <= 1'b0;
          fc_hold_reg[gi] <= 1'b0;
        end else begin
          adm_drop_reg[gi] <= drop_now[gi];
          adm_accept_reg[gi] <= adm_req[gi] && !drop_now[gi];
          // Pause once on reaching level, resume once on falling back
          if (!fc_hold_reg[gi] && used >= pause_lim) begin
            fc_hold_reg[gi] <= 1'b1;
            fc_pause_reg[gi] <= 1'b1; // see (R10)
            fc_resume_reg[gi] <= 1'b0;
          end else if (fc_hold_reg[gi] && used <= resume_lim) begin
            fc_hold_reg[gi] <= 1'b0;
            fc_pause_reg[gi] <= 1'b0;
            fc_resume_reg[gi] <= 1'b1; // see (R11)
          end else begin
            fc_pause_reg[gi] <= 1'b0;
            fc_resume_reg[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Static control outputs
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      egress_pace_en_reg <= 3'h0;
      fixed_prio_reg <= 1'b0;
    end else begin
      // Bit 4 is port 2, bit 2 is port 0
      egress_pace_en_reg <=
        cfg_reg[`SBAC_CFG_EGR_HI:`SBAC_CFG_EGR_LO]; // see (R03)
      fixed_prio_reg <= cfg_reg[`SBAC_CFG_FIXPRI]; // see (R02)
    end
  end

  // ----------------------------------------------------------------
  // Port 0 drop counter
  // ----------------------------------------------------------------
  sbac_drop_counter u_cnt0 (
    .clk_sys(clk_sys),
    .rst(rst),
    .drop(drop_now[0]), // see (R13)
    .rd_clr(rd_cnt0), // see (R14)
    .test_mode(cfg_reg[`SBAC_CFG_CTEST]), // see (R01)
    .count_reg(cnt0)
  );

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drop_cnt0_reg <= `SBAC_CNT_RST;
    end else begin
      drop_cnt0_reg <= cnt0;
    end
  end

endmodule

// ---- tb/sbac_top_monitor.sv ----
`timescale 1ns/1ps
`include "sbac_map.vh"
module sbac_top_monitor (
  input wire clk_sys,
  input wire rst,
  input wire csr_wr,
  input wire csr_rd,
  input wire [15:0] csr_addr,
  input wire [31:0] csr_wdata,
  input wire [31:0] csr_rdata_reg,
  input wire [23:0] port_used,
  input wire [2:0] adm_req,
  input wire [2:0] adm_flood,
  input wire [2:0] adm_red,
  input wire [2:0] adm_drop_reg,
  input wire [2:0] adm_accept_reg,
  input wire [2:0] fc_pause_reg,
  input wire [2:0] fc_resume_reg,
  input wire [2:0] fc_hold_reg,
  input wire [2:0] egress_pace_en_reg,
  input wire fixed_prio_reg,
  input wire [31:0] drop_cnt0_reg
);
  // ----------------------------------------
  // Shadow config, kept from observed writes
  // ----------------------------------------
  reg [6:0] cfg_reg;
  reg [15:0] lim_reg;
  reg [15:0] pau_reg;
  reg [15:0] rsm_reg;
  wire [7:0] u0 = port_used[7:0];
  wire on0 = u0 >= `SBAC_ACTIVE_LVL;
  wire on1 = port_used[15:8] >= `SBAC_ACTIVE_LVL;
  wire on2 = port_used[23:16] >= `SBAC_ACTIVE_LVL;
  wire two = (on0 & on1) | (on0 & on2) | (on1 & on2);
  wire [7:0] lim = two ? lim_reg[15:8] : lim_reg[7:0];
  wire [7:0] pau = two ? pau_reg[15:8] : pau_reg[7:0];
  wire [7:0] rsm = two ? rsm_reg[15:8] : rsm_reg[7:0];
  wire cnt_rd = csr_rd && csr_addr == `SBAC_IDX_CNT0;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_reg <= `SBAC_CFG_RST;
      lim_reg <= {`SBAC_DROP_LO_RST, `SBAC_DROP_HI_RST};
      pau_reg <= {`SBAC_PAUSE_LO_RST, `SBAC_PAUSE_HI_RST};
      rsm_reg <= {`SBAC_RESUME_LO_RST, `SBAC_RESUME_HI_RST};
    end else if (csr_wr) begin
      if (csr_addr == `SBAC_IDX_RESUME) rsm_reg <= csr_wdata[15:0];
      if (csr_addr == `SBAC_IDX_CFG) cfg_reg <= csr_wdata[6:0];
      if (csr_addr == `SBAC_IDX_DROP) lim_reg <= csr_wdata[15:0];
      if (csr_addr == `SBAC_IDX_PAUSE) pau_reg <= csr_wdata[15:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_cfg_out;
    csr_wr && csr_addr == `SBAC_IDX_CFG ##1 !csr_wr |=>
      {fixed_prio_reg, egress_pace_en_reg} == $past(csr_wdata[5:2], 2);
  endproperty
  a_cfg_out: assert property (p_cfg_out)
    else $error("static outputs differ from config");
  property p_rd_drop;
    csr_rd && !csr_wr && csr_addr == `SBAC_IDX_DROP |=>
      csr_rdata_reg == {16'h0000, lim_reg};
  endproperty
  a_rd_drop: assert property (p_rd_drop)
    else $error("drop limit readback wrong");
  property p_limit;
    adm_req[0] && u0 >= lim |=> adm_drop_reg[0] && !adm_accept_reg[0];
  endproperty
  a_limit: assert property (p_limit)
    else $error("over-limit request not dropped");
  property p_accept;
    adm_req[0] && u0 < lim && !adm_flood[0] && cfg_reg[1:0] == 2'h0 |=>
      adm_accept_reg[0] && !adm_drop_reg[0];
  endproperty
  a_accept: assert property (p_accept)
    else $error("under-limit request not admitted");
  property p_red;
    adm_req[0] && adm_red[0] && cfg_reg[0] |=> adm_drop_reg[0];
  endproperty
  a_red: assert property (p_red)
    else $error("red request not dropped");
  property p_cnt_inc;
    adm_drop_reg[0] && !$past(cnt_rd) && drop_cnt0_reg != `SBAC_CNT_MAX
      |=> drop_cnt0_reg == $past(drop_cnt0_reg) + 32'h1;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc)
    else $error("drop count did not step by one");
  property p_rd_clr;
    cnt_rd && !adm_req[0] |=> ##1
      drop_cnt0_reg == (cfg_reg[6] ? `SBAC_CNT_TEST : 32'h00000000);
  endproperty
  a_rd_clr: assert property (p_rd_clr)
    else $error("drop count not reloaded on read");
  property p_pause;
    !fc_hold_reg[0] && u0 >= pau |=> fc_pause_reg[0];
  endproperty
  a_pause: assert property (p_pause)
    else $error("pause not raised at level");
  property p_resume;
    fc_hold_reg[0] && u0 <= rsm |=> fc_resume_reg[0] && !fc_hold_reg[0];
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume not sent at level");
  c_drop: cover property (adm_drop_reg[0]);
  c_test_rd: cover property (cnt_rd && cfg_reg[6]);
  c_pause: cover property (fc_pause_reg[0]);
endmodule

bind sbac_top sbac_top_monitor u_mon (
  .clk_sys, .rst, .csr_wr, .csr_rd, .csr_addr, .csr_wdata, .csr_rdata_reg,
  .port_used, .adm_req, .adm_flood, .adm_red, .adm_drop_reg,
  .adm_accept_reg, .fc_pause_reg, .fc_resume_reg, .fc_hold_reg,
  .egress_pace_en_reg,
  .fixed_prio_reg, .drop_cnt0_reg
);

// ---- tb/sbac_top_test.sv ----
`timescale 1ns/1ps
`include "sbac_map.vh"
module sbac_top_test;
  logic clk_sys, rst, csr_wr, csr_rd, d;
  logic [15:0] csr_addr;
  logic [31:0] csr_wdata, cnt, r, s;
  logic [23:0] port_used;
  logic [7:0] flood_used, lim;
  logic [2:0] adm_req, adm_flood, adm_yellow, adm_red, adm_rand_hit;
  logic [6:0] cfg;
  wire [31:0] csr_rdata_reg, drop_cnt0_reg;
  wire [2:0] adm_drop_reg, adm_accept_reg, fc_pause_reg, fc_resume_reg;
  wire [2:0] fc_hold_reg, egress_pace_en_reg;
  wire fixed_prio_reg;
  logic [31:0] exp_rd [$];
  logic [1:0] exp_adm [$];
  logic [31:0] rst_tab [0:6] = '{32'h0, 32'h4964, 32'h213c, 32'h0307,
    32'h31, 32'h0, 32'h0};
  logic [31:0] one_tab [0:4] = '{32'h7f, 32'hffff, 32'hffff, 32'hffff,
    32'hff};
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int i;
  logic rd_seen;
  sbac_top uut (.clk_sys, .rst, .csr_wr, .csr_rd, .csr_addr, .csr_wdata,
    .csr_rdata_reg, .port_used, .flood_used, .adm_req, .adm_flood,
    .adm_yellow, .adm_red, .adm_rand_hit, .adm_drop_reg, .adm_accept_reg,
    .fc_pause_reg, .fc_resume_reg, .fc_hold_reg, .egress_pace_en_reg,
    .fixed_prio_reg, .drop_cnt0_reg);
  // ------------------------------
  // Drivers, result checks, ending
  // ------------------------------
  task cyc;
    @(posedge clk_sys);
    #1;
  endtask
  task reset_dut(input int n);
    rst = 1'b1;
    cnt = 32'h0;
    repeat (n) cyc;
    rst = 1'b0;
  endtask
  // Strobes drop for a cycle so back-to-back calls never re-drive them
  task wr(input [15:0] a, input [31:0] v);
    csr_wr = 1'b1;
    csr_addr = a;
    csr_wdata = v;
    cyc;
    csr_wr = 1'b0;
    cyc;
  endtask
  task rd(input [15:0] a, input [31:0] e);
    exp_rd.push_back(e);
    csr_rd = 1'b1;
    csr_addr = a;
    cyc;
    csr_rd = 1'b0;
    cyc;
  endtask
  task chk_rd;
    logic [31:0] e;
    e = exp_rd.pop_front();
    checked++;
    if (csr_rdata_reg !== e) begin
      bad_count++;
      $display("mismatch csr_rdata_reg exp %h got %h", e, csr_rdata_reg);
    end
  endtask
  task chk_adm;
    logic [1:0] e;
    e = exp_adm.pop_front();
    checked++;
    if ({adm_drop_reg[0], adm_accept_reg[0]} !== e) begin
      bad_count++;
      $display("mismatch adm0 exp %b got %b", e,
        {adm_drop_reg[0], adm_accept_reg[0]});
    end
  endtask
  task close_out;
    if (bad_count == 0 && checked > 0 && exp_adm.size() == 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    rd_seen = csr_rd;
    #2;
    if (rd_seen) chk_rd;
    if (adm_drop_reg[0] | adm_accept_reg[0]) chk_adm;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      close_out;
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    {csr_wr, csr_rd, csr_addr, csr_wdata, port_used, flood_used} = '0;
    {adm_req, adm_flood, adm_yellow, adm_red, adm_rand_hit} = '0;
    void'($urandom(32'hc64c5031));
    reset_dut(8);
    for (i = 0; i < 7; i++) rd(16'h1c00 + i[15:0], rst_tab[i]);
    for (i = 0; i < 5; i++) wr(16'h1c00 + i[15:0], 32'hffffffff);
    for (i = 0; i < 5; i++) rd(16'h1c00 + i[15:0], one_tab[i]);
    rd(`SBAC_IDX_CNT0, 32'h0);
    rd(`SBAC_IDX_CNT0, `SBAC_CNT_TEST);
    reset_dut(2);
    for (i = 0; i < 400; i++) begin
      if (i % 100 == 0) begin
        adm_req = 3'h0;
        cfg = {1'b0, 4'($urandom), 2'(i / 100)};
        wr(`SBAC_IDX_CFG, {25'h0, cfg});
      end
      r = $urandom;
      s = $urandom;
      port_used = {2'h0, r[29:24], 2'h0, r[21:16], 8'h40 + {2'h0, r[5:0]}};
      flood_used = r[15:8];
      {adm_req, adm_flood, adm_yellow, adm_red, adm_rand_hit} =
        {s[14:13], 1'b1, s[11:0]};
      // Port 0 sits at 40h or more, so it is always active
      lim = (r[29:24] >= 6'h24 || r[21:16] >= 6'h24) ? 8'h49 : 8'h64;
      d = port_used[7:0] >= lim || adm_flood[0] && flood_used >= 8'h31 ||
        adm_red[0] && cfg[0] || adm_yellow[0] && adm_rand_hit[0] && cfg[1];
      exp_adm.push_back({d, !d});
      cnt = cnt + d;
      cyc;
    end
    adm_req = 3'h0;
    cyc;
    cyc;
    rd(`SBAC_IDX_CNT0, cnt);
    rd(`SBAC_IDX_CNT0, 32'h0);
    close_out;
  end
endmodule
